// File: hdl/pam_pkg.sv
// Constants, types and helpers of the arbiter error monitor.
// Assumes that both register ports address words by a two-bit index.
`default_nettype none

package pam_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MASK = 2'h1;
  localparam logic [1:0] ADDR_LOG = 2'h2;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [31:0] STATUS_BITS = 32'h0000380F;
  localparam logic [31:0] LOG_BITS = 32'h0000001F;

  localparam int BIT_STALL = 13;
  localparam int BIT_TGT_TO = 12;
  localparam int BIT_MST_TO = 11;
  localparam int BIT_TABORT = 3;
  localparam int BIT_MABORT = 2;
  localparam int BIT_RD_PAR = 1;
  localparam int BIT_WR_PAR = 0;

  // ----------------------------------------------------------------
  // Events and bus timing, in link clock cycles
  // ----------------------------------------------------------------
  localparam int EV_W = 7;
  localparam int EV_STALL = 6;
  localparam int EV_TGT_TO = 5;
  localparam int EV_MST_TO = 4;
  localparam int EV_TABORT = 3;
  localparam int EV_MABORT = 2;
  localparam int EV_RD_PAR = 1;
  localparam int EV_WR_PAR = 0;
  localparam int OWNER_W = 5;
  localparam int CNT_W = 5;
  localparam int CMD_WRITE_BIT = 0;
  localparam logic [CNT_W-1:0] STALL_CLKS = 5'h10;
  localparam logic [CNT_W-1:0] TGT_FIRST_CLKS = 5'h10;
  localparam logic [CNT_W-1:0] TGT_NEXT_CLKS = 5'h08;
  localparam logic [CNT_W-1:0] IRDY_CLKS = 5'h08;
  localparam logic [CNT_W-1:0] PERR_TAIL_CLKS = 5'h02;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_GRANT,
    MON_XFER,
    MON_TAIL
  } pam_mon_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pam_place(input logic [EV_W-1:0] ev);
    logic [31:0] r;
    r = REG_RESET;
    r[BIT_STALL] = ev[EV_STALL];
    r[BIT_TGT_TO] = ev[EV_TGT_TO];
    r[BIT_MST_TO] = ev[EV_MST_TO];
    r[BIT_TABORT] = ev[EV_TABORT];
    r[BIT_MABORT] = ev[EV_MABORT];
    r[BIT_RD_PAR] = ev[EV_RD_PAR];
    r[BIT_WR_PAR] = ev[EV_WR_PAR];
    return r;
  endfunction

  function automatic logic [31:0] pam_read(input logic [1:0] a,
      input logic [31:0] st, input logic [31:0] mk, input logic [31:0] lg);
    logic [31:0] r;
    r = REG_RESET;
    if (a == ADDR_STATUS) r = st;
    if (a == ADDR_MASK) r = mk;
    if (a == ADDR_LOG) r = lg;
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] pam_inc(input logic [CNT_W-1:0] c);
    return (c == CNT_MAX) ? c : c + 5'h01;
  endfunction

endpackage

`default_nettype wire

// File: hdl/pam_sync.sv
// Three-stage synchroniser with agreement filter.
// Assumes d comes from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none

module pam_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] agree;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change is taken only once stages two and three agree.
  assign agree = ~(s2 ^ s3);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (s2 & agree) | (q & ~agree);
    end
  end

endmodule

`default_nettype wire

// File: hdl/pam_monitor.sv
// Arbiter error monitor: watches other masters on the link clock and
// keeps status, mask and owner log registers on the system clock.
// Assumes link pins are synchronous to pci_clk and that the register
// ports hold their request fields while the request is taken.
//
// Operation
// - Granted master not starting a frame within 16 clocks sets stall flag.
// - No TRDY or STOP within 16 (first) or 8 clocks sets bit 12.
// - Active master not asserting IRDY within 8 clocks sets bit 11.
// - Target abort in another master's transaction sets bit 3.
// - Master abort in another master's transaction sets bit 2.
// - PERR during another master's read data phase sets bit 1.
// - PERR during another master's write data phase sets bit 0.
// - A flag clears only on a written one; zero leaves it.
// - Flags set on errors whatever the mask holds.
// - Power-on or software reset clears status and mask to zero.
// - Reserved status, mask and log bits read zero; software writes zero.
// - Mask bit one enables, zero disables, the interrupt of the same-position flag.
// - On an error, one log bit marks the owning request line.
// - The log keeps the first error's owner, ignoring later ones.
// - Both register ports read all registers and clear flags.
// - Monitoring acts only in host mode with arbitration active.
// - Log bits 4 to 0 name request lines 4 to 0.
`timescale 1ns/1ps
`default_nettype none

module pam_monitor
  import pam_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic host_arb_en,
  input wire logic pb_sel,
  input wire logic pb_wr,
  input wire logic [1:0] pb_addr,
  input wire logic [31:0] pb_wdata,
  output logic [31:0] pb_rdata,
  output logic irq,
  input wire logic pci_clk,
  input wire logic pci_rst_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic perr_n,
  input wire logic [3:0] cbe_n,
  input wire logic [OWNER_W-1:0] gnt_n,
  input wire logic own_master,
  input wire logic pc_req,
  input wire logic pc_wr,
  input wire logic [1:0] pc_addr,
  input wire logic [31:0] pc_wdata,
  output logic pc_ack,
  output logic [31:0] pc_rdata
);

  // ----------------------------------------------------------------
  // Link side declarations
  // ----------------------------------------------------------------
  logic mon_en;
  pam_mon_e st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] tgt_limit;
  logic first;
  logic devsel_seen;
  logic is_write;
  logic xown;
  logic phase_done;
  logic [OWNER_W-1:0] owner;
  logic [OWNER_W-1:0] evt_owner;
  logic [EV_W-1:0] evt;
  logic [EV_W-1:0] tgl;
  logic pc_busy;
  logic req_tgl;
  logic hold_wr;
  logic [1:0] hold_addr;
  logic [31:0] hold_wdata;
  logic ack_q;
  logic ack_q_d;
  logic ack_pulse;

  // ----------------------------------------------------------------
  // System side declarations
  // ----------------------------------------------------------------
  logic [EV_W-1:0] tq;
  logic [EV_W-1:0] tq_d;
  logic [EV_W-1:0] evt_clk;
  logic req_q;
  logic req_q_d;
  logic req_pulse;
  logic ack_tgl;
  logic [31:0] rd_hold;
  logic [31:0] status;
  logic [31:0] mask;
  logic [31:0] owner_log;
  logic [31:0] set;
  logic [31:0] clr;

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  pam_sync #(.WIDTH(1)) u_en_sync (
    .clk(pci_clk),
    .rst_n(pci_rst_n),
    .d(host_arb_en),
    .q(mon_en)
  );

  pam_sync #(.WIDTH(1)) u_ack_sync (
    .clk(pci_clk),
    .rst_n(pci_rst_n),
    .d(ack_tgl),
    .q(ack_q)
  );

  pam_sync #(.WIDTH(EV_W)) u_evt_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(tgl),
    .q(tq)
  );

  pam_sync #(.WIDTH(1)) u_req_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(req_tgl),
    .q(req_q)
  );

  // ----------------------------------------------------------------
  // Transaction tracker
  // ----------------------------------------------------------------
  assign phase_done = !irdy_n && (!trdy_n || !stop_n);
  assign tgt_limit = first ? TGT_FIRST_CLKS : TGT_NEXT_CLKS;

  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      st <= MON_IDLE;
      cnt <= '0;
      first <= 1'b0;
      devsel_seen <= 1'b0;
      is_write <= 1'b0;
      xown <= 1'b0;
      owner <= '0;
    end else if (!mon_en) begin
      st <= MON_IDLE;
      cnt <= '0;
    end else begin
      unique case (st)
        MON_IDLE, MON_GRANT: begin
          owner <= ~gnt_n;
          if (!frame_n) begin
            st <= MON_XFER;
            cnt <= '0;
            first <= 1'b1;
            devsel_seen <= 1'b0;
            is_write <= cbe_n[CMD_WRITE_BIT];
            xown <= own_master;
          end else if (gnt_n != '1) begin
            st <= MON_GRANT;
            cnt <= (st == MON_GRANT) ? pam_inc(cnt) : '0;
          end else begin
            st <= MON_IDLE;
          end
        end
        MON_XFER: begin
          if (!devsel_n) devsel_seen <= 1'b1;
          if (frame_n && irdy_n) begin
            st <= MON_TAIL;
            cnt <= '0;
          end else if (phase_done) begin
            first <= 1'b0;
            cnt <= '0;
            if (frame_n) st <= MON_TAIL;
          end else begin
            cnt <= pam_inc(cnt);
          end
        end
        MON_TAIL: begin
          if (cnt == PERR_TAIL_CLKS - 5'h01) begin
            st <= MON_IDLE;
            cnt <= '0;
          end else begin
            cnt <= pam_inc(cnt);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  always_comb begin
    evt = '0;
    if (mon_en) begin
      if (st == MON_GRANT && frame_n && gnt_n != '1 &&
          cnt == STALL_CLKS - 5'h01) begin
        evt[EV_STALL] = 1'b1;
      end
      if (st == MON_XFER && !xown) begin
        if (!phase_done && cnt == tgt_limit - 5'h01) begin
          evt[EV_TGT_TO] = 1'b1;
        end
        if (irdy_n && !frame_n && cnt == IRDY_CLKS - 5'h01) begin
          evt[EV_MST_TO] = 1'b1;
        end
        if (!stop_n && devsel_n && devsel_seen) begin
          evt[EV_TABORT] = 1'b1;
        end
        if (frame_n && irdy_n && !devsel_seen) begin
          evt[EV_MABORT] = 1'b1;
        end
      end
      if ((st == MON_XFER || st == MON_TAIL) && !xown && !perr_n) begin
        evt[EV_RD_PAR] = !is_write;
        evt[EV_WR_PAR] = is_write;
      end
    end
  end

  // Each event flips its own toggle, so two different errors in one
  // cycle both reach the system side.
  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      tgl <= '0;
      evt_owner <= '0;
    end else begin
      tgl <= tgl ^ evt;
      if (evt != '0) evt_owner <= owner;
    end
  end

  // ----------------------------------------------------------------
  // Link side register port
  // ----------------------------------------------------------------
  assign ack_pulse = ack_q ^ ack_q_d;

  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      pc_busy <= 1'b0;
      req_tgl <= 1'b0;
      hold_wr <= 1'b0;
      hold_addr <= '0;
      hold_wdata <= REG_RESET;
    end else if (pc_req && !pc_busy) begin
      pc_busy <= 1'b1;
      req_tgl <= ~req_tgl;
      hold_wr <= pc_wr;
      hold_addr <= pc_addr;
      hold_wdata <= pc_wdata;
    end else if (ack_pulse) begin
      pc_busy <= 1'b0;
    end
  end

  always_ff @(posedge pci_clk) begin
    if (!pci_rst_n) begin
      ack_q_d <= 1'b0;
      pc_ack <= 1'b0;
      pc_rdata <= REG_RESET;
    end else begin
      ack_q_d <= ack_q;
      pc_ack <= ack_pulse;
      if (ack_pulse) pc_rdata <= rd_hold;
    end
  end

  // ----------------------------------------------------------------
  // System side request handling
  // ----------------------------------------------------------------
  assign evt_clk = tq ^ tq_d;
  assign req_pulse = req_q ^ req_q_d;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tq_d <= '0;
      req_q_d <= 1'b0;
      ack_tgl <= 1'b0;
      rd_hold <= REG_RESET;
    end else begin
      tq_d <= tq;
      req_q_d <= req_q;
      ack_tgl <= ack_tgl ^ req_pulse;
      if (req_pulse) begin
        rd_hold <= pam_read(hold_addr, status, mask, owner_log);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb begin
    set = pam_place(evt_clk);
    clr = REG_RESET;
    if (pb_sel && pb_wr && pb_addr == ADDR_STATUS) begin
      clr = clr | pb_wdata;
    end
    if (req_pulse && hold_wr && hold_addr == ADDR_STATUS) begin
      clr = clr | hold_wdata;
    end
  end

  // A new error wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      status <= REG_RESET;
    end else begin
      status <= ((status & ~clr) | set) & STATUS_BITS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || sw_reset) begin
      mask <= REG_RESET;
    end else if (pb_sel && pb_wr && pb_addr == ADDR_MASK) begin
      mask <= pb_wdata & STATUS_BITS;
    end else if (req_pulse && hold_wr && hold_addr == ADDR_MASK) begin
      mask <= hold_wdata & STATUS_BITS;
    end
  end

  // Owner data cross as a word that stays put for many link cycles
  // after its toggle; two errors by different owners inside a few
  // cycles could mix, which the first-error-only log tolerates.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      owner_log <= REG_RESET;
    end else if (set != REG_RESET && (status & ~clr) == REG_RESET) begin
      owner_log <= 32'(evt_owner) & LOG_BITS;
    end
  end

  assign irq = |(status & mask);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pb_rdata <= REG_RESET;
    end else if (pb_sel && !pb_wr) begin
      pb_rdata <= pam_read(pb_addr, status, mask, owner_log);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stall_event_a: assert property (@(posedge pci_clk) disable iff (!pci_rst_n)
    (mon_en && st == MON_GRANT && frame_n && gnt_n != '1 &&
     cnt == STALL_CLKS - 5'h01) |=> tgl[EV_STALL] != $past(tgl[EV_STALL]))
    else $error("Stall event missed.");

  tgt_timeout_a: assert property (@(posedge pci_clk) disable iff (!pci_rst_n)
    (mon_en && st == MON_XFER && !xown && first && !phase_done &&
     cnt == TGT_FIRST_CLKS - 5'h01) |=> $changed(tgl[EV_TGT_TO]))
    else $error("Target timeout missed.");

  mst_timeout_a: assert property (@(posedge pci_clk) disable iff (!pci_rst_n)
    (mon_en && st == MON_XFER && !xown && irdy_n && !frame_n &&
     cnt == IRDY_CLKS - 5'h01) |=> $changed(tgl[EV_MST_TO]))
    else $error("Master timeout missed.");

  gate_off_a: assert property (@(posedge pci_clk) disable iff (!pci_rst_n)
    !mon_en |=> $stable(tgl))
    else $error("Event raised outside host mode.");

  flag_sets_a: assert property (@(posedge clk) disable iff (!rst_n)
    (set != REG_RESET && !sw_reset) |=> (status & $past(set)) == $past(set))
    else $error("Flag not set on error.");

  zero_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clr == REG_RESET && set == REG_RESET && !sw_reset) |=> $stable(status))
    else $error("Flag changed without cause.");

  soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_reset |=> status == REG_RESET && mask == REG_RESET)
    else $error("Software reset left state.");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (status & ~STATUS_BITS) == REG_RESET && (mask & ~STATUS_BITS) == REG_RESET
    && (owner_log & ~LOG_BITS) == REG_RESET)
    else $error("Reserved bit set.");

  log_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (status != REG_RESET && clr == REG_RESET) |=> $stable(owner_log))
    else $error("Owner log overwritten.");

  irq_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((set & mask) != REG_RESET && !sw_reset && !(pb_sel && pb_wr)
     && !req_pulse) |=> irq)
    else $error("Interrupt not raised.");

  stall_seen_c: cover property (@(posedge pci_clk) evt[EV_STALL]);
  tabort_seen_c: cover property (@(posedge pci_clk) evt[EV_TABORT]);
  link_read_c: cover property (@(posedge pci_clk) pc_ack);
  irq_seen_c: cover property (@(posedge clk) $rose(irq));

endmodule

`default_nettype wire

// File: verif/pam_bus_model.sv
// Behavioural model of the other masters, targets and arbiter grants.
// Assumes the caller runs its tasks one at a time; lines idle high.
`timescale 1ns/1ps
`default_nettype none

module pam_bus_model (
  input wire logic pci_clk,
  output logic frame_n,
  output logic irdy_n,
  output logic trdy_n,
  output logic stop_n,
  output logic devsel_n,
  output logic perr_n,
  output logic [3:0] cbe_n,
  output logic [4:0] gnt_n,
  output logic own_master
);
  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  // Released lines show their pull-up level, never the last value.
  initial begin
    {frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n} = 6'h3F;
    cbe_n = 4'hF;
    gnt_n = 5'h1F;
    own_master = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Bits of b: frame, irdy, trdy, stop, devsel, perr, all active low.
  task automatic cyc(input logic [4:0] g, input logic [5:0] b,
      input int n);
    repeat (n) begin
      gnt_n = g;
      {frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n} = b;
      @(posedge pci_clk);
      #2;
    end
  endtask

  task automatic stall(input int line);
    @(posedge pci_clk);
    #2;
    cyc(5'(~(5'h01 << line)), 6'h3F, 20);
    cyc(5'h1F, 6'h3F, 2);
  endtask

  // Kinds: 0 target stall, 1 initiator stall, 2 target abort,
  // 3 no target claims, 4 parity report, 5 stall after first phase,
  // 6 first phase slow but inside its limit.
  task automatic txn(input int line, input logic wr, input logic own,
      input int kind);
    logic [4:0] g;
    g = 5'(~(5'h01 << line));
    @(posedge pci_clk);
    #2;
    cyc(g, 6'h3F, 1);
    own_master = own;
    cbe_n = wr ? 4'h7 : 4'h6;
    cyc(g, 6'h1F, 1);
    own_master = 1'b0;
    cbe_n = 4'h0;
    case (kind)
      0: cyc(g, 6'h0D, 18);
      1: cyc(g, 6'h1D, 10);
      2: cyc(g, 6'h0D, 1);
      3: cyc(g, 6'h2F, 4);
      5: begin
        cyc(g, 6'h05, 1);
        cyc(g, 6'h0D, 10);
      end
      6: cyc(g, 6'h0D, 12);
      default: ;
    endcase
    if (kind == 2) begin
      cyc(g, 6'h2B, 1);
    end else if (kind != 3) begin
      cyc(g, 6'h25, 1);
    end
    cbe_n = 4'hF;
    cyc(5'h1F, (kind == 4) ? 6'h3E : 6'h3F, 1);
    cyc(5'h1F, 6'h3F, 4);
  endtask
endmodule

`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench of the arbiter error monitor.
// Assumes the monitor top in the hdl folder and the bus model beside it in this folder.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import pam_pkg::*;
;
  logic clk, rst_n, sw_reset, host_arb_en, pb_sel, pb_wr, irq;
  logic [1:0] pb_addr, pc_addr;
  logic [31:0] pb_wdata, pb_rdata, pc_wdata, pc_rdata, q;
  logic pci_clk, pci_rst_n, pc_req, pc_wr, pc_ack, own_master;
  logic frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n;
  logic [3:0] cbe_n;
  logic [4:0] gnt_n;
  int errors, checked;
  int kd[4] = '{2, 3, 4, 4};
  logic wrs[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [31:0] ex[4] = '{32'h8, 32'h4, 32'h2, 32'h1};

  pam_monitor u_dut (.clk(clk), .rst_n(rst_n), .sw_reset(sw_reset),
    .host_arb_en(host_arb_en), .pb_sel(pb_sel), .pb_wr(pb_wr),
    .pb_addr(pb_addr), .pb_wdata(pb_wdata), .pb_rdata(pb_rdata),
    .irq(irq), .pci_clk(pci_clk), .pci_rst_n(pci_rst_n),
    .frame_n(frame_n), .irdy_n(irdy_n), .trdy_n(trdy_n),
    .stop_n(stop_n), .devsel_n(devsel_n), .perr_n(perr_n),
    .cbe_n(cbe_n), .gnt_n(gnt_n), .own_master(own_master),
    .pc_req(pc_req), .pc_wr(pc_wr), .pc_addr(pc_addr),
    .pc_wdata(pc_wdata), .pc_ack(pc_ack), .pc_rdata(pc_rdata));

  pam_bus_model u_bus (.pci_clk(pci_clk), .frame_n(frame_n),
    .irdy_n(irdy_n), .trdy_n(trdy_n), .stop_n(stop_n),
    .devsel_n(devsel_n), .perr_n(perr_n), .cbe_n(cbe_n),
    .gnt_n(gnt_n), .own_master(own_master));

  // ----------------------------------------------------------------
  // Clocks and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The link clock has its own phase so crossings see varied skew.
  initial begin
    pci_clk = 1'b0;
    #17;
    forever #62.5 pci_clk = ~pci_clk;
  end

  task automatic give_verdict;
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1000000;
    errors++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pb_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    #2;
    {pb_sel, pb_wr, pb_addr, pb_wdata} = {2'b11, a, d};
    @(posedge clk);
    #2;
    {pb_sel, pb_wr} = 2'b00;
  endtask

  task automatic pb_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    #2;
    {pb_sel, pb_wr, pb_addr} = {2'b10, a};
    @(posedge clk);
    #2;
    pb_sel = 1'b0;
    d = pb_rdata;
  endtask

  task automatic rd_chk(input string n, input logic [1:0] a,
      input logic [31:0] exp);
    logic [31:0] d;
    pb_rd(a, d);
    chk(n, d, exp);
  endtask

  // Polls because the flag crosses two clock domains first.
  task automatic wait_st(input logic [31:0] exp);
    logic [31:0] d;
    int k;
    k = 0;
    d = 32'h0;
    while (d !== exp && k < 60) begin
      pb_rd(ADDR_STATUS, d);
      k++;
    end
    chk("status", d, exp);
  endtask

  task automatic pc_acc(input logic w, input logic [1:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge pci_clk);
    #2;
    {pc_req, pc_wr, pc_addr, pc_wdata} = {1'b1, w, a, d};
    @(posedge pci_clk);
    #2;
    pc_req = 1'b0;
    k = 0;
    while (pc_ack !== 1'b1 && k < 40) begin
      @(posedge pci_clk);
      #2;
      k++;
    end
    chk("link ack", {31'h0, pc_ack}, 32'h1);
    r = pc_rdata;
  endtask

  task automatic quiet;
    repeat (40) @(posedge clk);
    rd_chk("status", ADDR_STATUS, REG_RESET);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n, pci_rst_n, sw_reset, pb_sel, pb_wr, pc_req, pc_wr} = 7'h0;
    {pb_addr, pc_addr, pb_wdata, pc_wdata} = 68'h0;
    host_arb_en = 1'b1;
    errors = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    #2;
    rst_n = 1'b1;
    @(posedge pci_clk);
    #2;
    pci_rst_n = 1'b1;
    repeat (10) @(posedge clk);
    rd_chk("status", ADDR_STATUS, REG_RESET);
    rd_chk("mask", ADDR_MASK, REG_RESET);
    rd_chk("log", ADDR_LOG, REG_RESET);
    pb_write(ADDR_MASK, 32'hFFFFFFFF);
    rd_chk("mask", ADDR_MASK, STATUS_BITS);
    pb_write(2'h3, 32'h5A5A5A5A);
    rd_chk("unmapped", 2'h3, 32'h0);
    pb_write(ADDR_MASK, 32'h0);
    u_bus.stall(0);
    wait_st(32'h00002000);
    chk("irq", {31'h0, irq}, 32'h0);
    rd_chk("log", ADDR_LOG, 32'h1);
    pb_write(ADDR_MASK, 32'h00002000);
    chk("irq", {31'h0, irq}, 32'h1);
    pb_write(ADDR_MASK, 32'h00001000);
    chk("irq", {31'h0, irq}, 32'h0);
    pb_write(ADDR_STATUS, 32'h0);
    rd_chk("status", ADDR_STATUS, 32'h00002000);
    pb_write(ADDR_STATUS, 32'h00002000);
    rd_chk("status", ADDR_STATUS, 32'h0);
    u_bus.txn(4, 1'b1, 1'b0, 0);
    wait_st(32'h00001000);
    chk("irq", {31'h0, irq}, 32'h1);
    u_bus.txn(2, 1'b1, 1'b0, 1);
    wait_st(32'h00001800);
    rd_chk("log", ADDR_LOG, 32'h10);
    pb_write(ADDR_STATUS, 32'h00001800);
    u_bus.txn(1, 1'b1, 1'b0, 5);
    wait_st(32'h00001000);
    rd_chk("log", ADDR_LOG, 32'h2);
    pb_write(ADDR_STATUS, 32'h00001000);
    u_bus.txn(1, 1'b1, 1'b0, 6);
    quiet;
    for (int i = 0; i < 4; i++) begin
      u_bus.txn(i, wrs[i], 1'b0, kd[i]);
      wait_st(ex[i]);
      rd_chk("log", ADDR_LOG, 32'h1 << i);
      pc_acc(1'b1, ADDR_STATUS, ex[i], q);
      chk("link status", q, ex[i]);
      rd_chk("status", ADDR_STATUS, 32'h0);
    end
    u_bus.txn(2, 1'b1, 1'b1, 3);
    quiet;
    u_bus.txn(3, 1'b1, 1'b1, 2);
    quiet;
    host_arb_en = 1'b0;
    repeat (20) @(posedge clk);
    u_bus.txn(2, 1'b1, 1'b0, 3);
    quiet;
    host_arb_en = 1'b1;
    repeat (20) @(posedge clk);
    pc_acc(1'b0, ADDR_MASK, 32'h0, q);
    chk("link mask", q, 32'h00001000);
    u_bus.stall(3);
    wait_st(32'h00002000);
    @(posedge clk);
    #2;
    sw_reset = 1'b1;
    @(posedge clk);
    #2;
    sw_reset = 1'b0;
    rd_chk("status", ADDR_STATUS, REG_RESET);
    rd_chk("mask", ADDR_MASK, REG_RESET);
    give_verdict;
  end
endmodule

`default_nettype wire
